// [src/cft_pkg.sv]
/*
 * cft_pkg: constants, types and register map of the function timer.
 * assumes a 125 MHz system clock and an AXI4-Lite register bus.
 */
package cft_pkg;

   // register byte offsets
   localparam logic [7:0] CFT_OFF_CTRL = 8'h00;
   localparam logic [7:0] CFT_OFF_TIME = 8'h04;
   localparam logic [7:0] CFT_OFF_ELAP = 8'h08;
   localparam logic [7:0] CFT_OFF_STAT = 8'h0c;
   localparam logic [7:0] CFT_OFF_PRE = 8'h10;

   // control field positions
   localparam int CFT_CTRL_MODE_LSB = 0;
   localparam int CFT_CTRL_RUN_LVL = 4;
   localparam int CFT_CTRL_CLR_LVL = 5;
   localparam int CFT_CTRL_OUT_LVL = 6;

   // time values are in thousandths of a unit
   localparam int CFT_TIME_W = 27;
   localparam logic [26:0] CFT_TIME_MAX = 27'h5f5dd18;
   localparam logic [26:0] CFT_RET_MAX = 27'h1c9c380;

   // one thousandth of a unit is one tick: 1 ms at 125 MHz
   localparam int CFT_TICK_NS = 1000000;
   localparam int CFT_CLK_NS = 8;
   localparam int CFT_TICK_CYC = CFT_TICK_NS / CFT_CLK_NS;

   localparam logic [31:0] CFT_CTRL_RST = 32'h0000_0050;

   typedef enum logic [2:0] {
      CFT_OFF,
      CFT_PULSE,
      CFT_DELAY,
      CFT_ONESHOT,
      CFT_RETENT
   } cft_mode_e;

   typedef struct packed {
      logic [2:0] mode;
      logic run_lvl;
      logic clr_lvl;
      logic out_lvl;
   } cft_cfg_s;

endpackage

// [src/cft_timer.sv]
/*
 * cft_timer: configurable function timer (off, on-pulse, delay, one-shot,
 * retentive) with an AXI4-Lite register slave.
 * assumes run/clear come from another clock domain or pins and are
 * synchronised here; one clock, asynchronous active-low reset.
 */
// Register access over AXI4-Lite and the register offsets were chosen for this implementation.
// How it works
// - on-pulse: active run edge sets output, times out after programmed time
// - on-pulse: programmed time gives pulse length, 0 to 99999.000 units
// - on-pulse: run level setting picks rising or falling trigger edge
// - output level setting gives the output's active polarity
// - on-pulse: elapsed shows time since trigger, zero when idle
// - elapsed count is zero after every reset
// - delay: count while input active; at time, output active, count freezes
// - delay: input inactive clears output and elapsed at once
// - delay: activation shorter than time never sets output
// - delay: time is needed continuous active duration, 0 to 99999.000
// - delay: run level picks which input transition is delayed
// - one-shot: output active whenever remaining time above zero
// - one-shot: remaining time counts down only while run active
// - one-shot: at zero, output inactive, elapsed cleared, time lost
// - one-shot: elapsed counts up only while countdown runs
// - one-shot: run level chooses the counting input level
// - one-shot: remaining time is zero after reset
// - retentive: elapsed grows with run active and clear inactive
// - retentive: output latches active once accumulated reaches time
// - retentive: clear edge forces output inactive and zeroes elapsed
// - retentive: accumulation goes on past the programmed time
// - off mode holds output at the inactive level
// - retentive: clear level setting picks the resetting clear edge
// - retentive: threshold and elapsed span 0 to 30000.0 units
module cft_timer #(
   parameter int TICK_CYC = cft_pkg::CFT_TICK_CYC
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // timer pins
   input wire logic run_i,
   input wire logic clr_i,
   output logic timer_o,
   // axi4-lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   localparam int W = cft_pkg::CFT_TIME_W;

   cft_pkg::cft_cfg_s cfg_q;
   logic [W-1:0] time_q;
   logic [W-1:0] elap_q;
   logic [31:0] pre_cnt_q;
   logic tick;
   logic [1:0] run_sync_q;
   logic [1:0] clr_sync_q;
   logic run_prev_q;
   logic clr_prev_q;
   logic act_q;
   logic busy_q;
   logic run_act;
   logic run_edge;
   logic clr_edge;
   logic clr_act;
   logic time_wr;
   logic [W-1:0] wr_time;
   logic [W-1:0] time_lim;

   // write channel state
   logic [7:0] aw_addr_q;
   logic aw_have_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic w_have_q;
   logic [31:0] ctrl_word;
   logic [31:0] ctrl_new;
   logic [31:0] time_new;
   logic [31:0] rd_mux;
   logic rd_ok;

   // prescaler: one tick enable per thousandth of a unit
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pre_cnt_q <= 32'h0000_0000;
      end else if (pre_cnt_q >= 32'(TICK_CYC - 1)) begin
         pre_cnt_q <= 32'h0000_0000;
      end else begin
         pre_cnt_q <= pre_cnt_q + 32'h0000_0001;
      end
   end
   assign tick = (pre_cnt_q >= 32'(TICK_CYC - 1));

   // input synchronisers, then edge detect against previous sample
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         run_sync_q <= 2'h0;
         clr_sync_q <= 2'h0;
         run_prev_q <= 1'b0;
         clr_prev_q <= 1'b0;
      end else begin
         run_sync_q <= {run_sync_q[0], run_i};
         clr_sync_q <= {clr_sync_q[0], clr_i};
         run_prev_q <= run_sync_q[1];
         clr_prev_q <= clr_sync_q[1];
      end
   end

   // active level: high -> on is active, low -> off is active
   assign run_act = (run_sync_q[1] == cfg_q.run_lvl);
   assign run_edge = run_act && (run_prev_q != run_sync_q[1]);
   // clear held at its active level blocks accumulation, not only its edge
   assign clr_act = (clr_sync_q[1] == cfg_q.clr_lvl);
   assign clr_edge = clr_act && (clr_prev_q != clr_sync_q[1]);

   // register write decode
   assign ctrl_word = {25'h0, cfg_q.out_lvl, cfg_q.clr_lvl, cfg_q.run_lvl, 1'b0, cfg_q.mode};
   always_comb begin
      ctrl_new = ctrl_word;
      time_new = {5'h00, time_q};
      for (int b = 0; b < 4; b++) begin
         if (w_strb_q[b]) begin
            ctrl_new[8*b +: 8] = w_data_q[8*b +: 8];
            time_new[8*b +: 8] = w_data_q[8*b +: 8];
         end
      end
   end
   assign time_wr = aw_have_q && w_have_q && !s_axi_bvalid && (aw_addr_q == cft_pkg::CFT_OFF_TIME);
   // clamp to the mode's documented range
   assign time_lim = (cfg_q.mode == 3'(cft_pkg::CFT_RETENT)) ? cft_pkg::CFT_RET_MAX
                                                             : cft_pkg::CFT_TIME_MAX;
   assign wr_time = (time_new[W-1:0] > time_lim) ? time_lim : time_new[W-1:0];

   // configuration register
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         // taken from the one reset constant so a read after reset matches it
         cfg_q <= '{mode: cft_pkg::CFT_CTRL_RST[cft_pkg::CFT_CTRL_MODE_LSB +: 3],
                    run_lvl: cft_pkg::CFT_CTRL_RST[cft_pkg::CFT_CTRL_RUN_LVL],
                    clr_lvl: cft_pkg::CFT_CTRL_RST[cft_pkg::CFT_CTRL_CLR_LVL],
                    out_lvl: cft_pkg::CFT_CTRL_RST[cft_pkg::CFT_CTRL_OUT_LVL]};
      end else if (aw_have_q && w_have_q && !s_axi_bvalid
                   && aw_addr_q == cft_pkg::CFT_OFF_CTRL) begin
         cfg_q.mode <= (ctrl_new[2:0] > 3'(cft_pkg::CFT_RETENT)) ? 3'h0 : ctrl_new[2:0];
         cfg_q.run_lvl <= ctrl_new[cft_pkg::CFT_CTRL_RUN_LVL];
         cfg_q.clr_lvl <= ctrl_new[cft_pkg::CFT_CTRL_CLR_LVL];
         cfg_q.out_lvl <= ctrl_new[cft_pkg::CFT_CTRL_OUT_LVL];
      end
   end

   // timer core: time, elapsed, active and running state
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         time_q <= '0;
         elap_q <= '0;
         act_q <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         if (time_wr) begin
            time_q <= wr_time;
         end
         unique case (cft_pkg::cft_mode_e'(cfg_q.mode))
            cft_pkg::CFT_OFF: begin
               elap_q <= '0;
               act_q <= 1'b0;
               busy_q <= 1'b0;
            end
            cft_pkg::CFT_PULSE: begin
               // an edge while running does not restart the pulse; its cycle skips the tick and timeout checks
               if (run_edge) begin
                  busy_q <= 1'b1;
                  act_q <= 1'b1;
               end else if (busy_q && elap_q >= time_q) begin
                  busy_q <= 1'b0;
                  act_q <= 1'b0;
                  elap_q <= '0;
               end else if (busy_q && tick) begin
                  elap_q <= elap_q + 1'b1;
               end else if (!busy_q) begin
                  elap_q <= '0;
               end
            end
            cft_pkg::CFT_DELAY: begin
               busy_q <= 1'b0;
               if (!run_act) begin
                  elap_q <= '0;
                  act_q <= 1'b0;
               end else if (elap_q >= time_q) begin
                  elap_q <= time_q;
                  act_q <= 1'b1;
               end else if (tick) begin
                  elap_q <= elap_q + 1'b1;
               end
            end
            cft_pkg::CFT_ONESHOT: begin
               busy_q <= 1'b0;
               // a time write wins over a countdown tick in the same cycle
               if (time_wr) begin
                  elap_q <= '0;
                  act_q <= (wr_time != '0);
               end else if (time_q == '0) begin
                  act_q <= 1'b0;
                  elap_q <= '0;
               end else begin
                  act_q <= 1'b1;
                  if (run_act && tick) begin
                     time_q <= time_q - 1'b1;
                     elap_q <= elap_q + 1'b1;
                  end
               end
            end
            cft_pkg::CFT_RETENT: begin
               busy_q <= 1'b0;
               if (clr_edge) begin
                  elap_q <= '0;
                  act_q <= 1'b0;
               end else begin
                  if (run_act && !clr_act && tick && elap_q < cft_pkg::CFT_RET_MAX) begin
                     elap_q <= elap_q + 1'b1;
                  end
                  if (elap_q >= time_q) begin
                     act_q <= 1'b1;
                  end
               end
            end
            default: begin
               elap_q <= '0;
               act_q <= 1'b0;
               busy_q <= 1'b0;
            end
         endcase
      end
   end

   // output polarity
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         timer_o <= 1'b0;
      end else begin
         timer_o <= act_q ? cfg_q.out_lvl : ~cfg_q.out_lvl;
      end
   end

   // axi write: address and data taken in either order, response after both
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= {s_axi_awaddr[7:2], 2'h0};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         // unmapped writes change nothing but still get an error response
         if (aw_have_q && w_have_q && !s_axi_bvalid) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr_q == cft_pkg::CFT_OFF_CTRL
                            || aw_addr_q == cft_pkg::CFT_OFF_TIME) ? 2'h0 : 2'h2;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
         s_axi_wready <= !w_have_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      end
   end

   // axi read: one cycle after the address is taken
   // rdata decodes araddr directly; a compliant master holds it until taken
   always_comb begin
      rd_ok = 1'b1;
      unique case ({s_axi_araddr[7:2], 2'h0})
         cft_pkg::CFT_OFF_CTRL: rd_mux = ctrl_word;
         cft_pkg::CFT_OFF_TIME: rd_mux = {5'h00, time_q};
         cft_pkg::CFT_OFF_ELAP: rd_mux = {5'h00, elap_q};
         cft_pkg::CFT_OFF_STAT: rd_mux = {30'h0, busy_q, act_q};
         cft_pkg::CFT_OFF_PRE: rd_mux = pre_cnt_q;
         default: begin
            rd_mux = 32'h0000_0000;
            rd_ok = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'h0;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule

// [tb/cft_timer_monitor.sv]
/* cft_timer_monitor: port checks for cft_timer, bus handshakes and output at reset.
   assumes it is bound to every cft_timer instance. */
module cft_timer_monitor (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // watched ports
   input wire logic timer_o,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   property p_wr_ans;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
   endproperty
   a_wr_ans: assert property (p_wr_ans) else $error("no write response");
   property p_rd_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_rd_ans: assert property (p_rd_ans) else $error("no read data");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped");
   property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_ar_block: assert property (p_ar_block) else $error("read address taken early");
   property p_w_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
   a_w_block: assert property (p_w_block) else $error("write taken early");
   property p_rresp; s_axi_rvalid |-> s_axi_rresp == 2'h0 || s_axi_rresp == 2'h2; endproperty
   a_rresp: assert property (p_rresp) else $error("bad read response");
   // mode is off after reset, so output sits at the inactive level
   property p_rst_out; $rose(rst_n_i) |-> !timer_o; endproperty
   a_rst_out: assert property (p_rst_out) else $error("output active after reset");
   c_wr: cover property (s_axi_bvalid && s_axi_bready);
   c_rd: cover property (s_axi_rvalid && s_axi_rready);
   c_out: cover property ($rose(timer_o));
endmodule

bind cft_timer cft_timer_monitor u_mon (
   .clk_i(clk_i), .rst_n_i(rst_n_i), .timer_o(timer_o),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// [tb/cft_far_end.sv]
/* cft_far_end: logic that drives the run and clear pins of the timer.
   assumes commands from the bench; pins change only just after an edge. */
module cft_far_end (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // commands
   input wire logic run_cmd_i,
   input wire logic clr_cmd_i,
   // timer pins
   output logic run_o,
   output logic clr_o
);
   timeunit 1ns;
   timeprecision 1ps;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         run_o <= 1'b0;
         clr_o <= 1'b0;
      end else begin
         run_o <= run_cmd_i;
         clr_o <= clr_cmd_i;
      end
   end
endmodule

// [tb/testbench.sv]
/* testbench: mode scenarios for cft_timer over axi4-lite and its pins.
   assumes a tick of TC cycles; elapsed and time read in ticks. */
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TC = 4;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic run_cmd = 1'b0;
   logic clr_cmd = 1'b0;
   logic run_w, clr_w, timer_o, awready, wready, bvalid, arready, rvalid;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, rd, e1;
   logic [1:0] bresp, rresp, rsp, wsp;
   int n_errors = 0;
   int n_compared = 0;

   initial forever #4 clk_i = ~clk_i;

   cft_far_end far (.clk_i(clk_i), .rst_n_i(rst_n_i), .run_cmd_i(run_cmd),
      .clr_cmd_i(clr_cmd), .run_o(run_w), .clr_o(clr_w));
   cft_timer #(.TICK_CYC(TC)) uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .run_i(run_w),
      .clr_i(clr_w), .timer_o(timer_o), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // bready raised late on purpose so the response has to stand a cycle
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk_i);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      for (i = 0; i < 40; i++) begin
         @(posedge clk_i);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid && bready) break;
         if (bvalid) bready <= 1'b1;
      end
      bready <= 1'b0;
      wsp = bresp;
      if (i == 40) chk(32'h1, 32'h0);
   endtask

   task automatic rdr(input logic [7:0] a);
      int i;
      @(posedge clk_i);
      araddr <= a;
      arvalid <= 1'b1;
      for (i = 0; i < 40; i++) begin
         @(posedge clk_i);
         if (arready) arvalid <= 1'b0;
         if (rvalid && rready) break;
         if (rvalid) rready <= 1'b1;
      end
      rready <= 1'b0;
      rd = rdata;
      rsp = rresp;
      if (i == 40) chk(32'h1, 32'h0);
   endtask

   task automatic pin(input logic r, input logic c, input int n);
      @(posedge clk_i);
      run_cmd <= r;
      clr_cmd <= c;
      repeat (n) @(posedge clk_i);
   endtask

   task automatic t_reset();
      rdr(cft_pkg::CFT_OFF_CTRL);
      chk(rd, cft_pkg::CFT_CTRL_RST);
      chk(rsp, 2'h0);
      rdr(cft_pkg::CFT_OFF_ELAP);
      chk(rd, 32'h0);
      rdr(cft_pkg::CFT_OFF_TIME);
      chk(rd, 32'h0);
      chk(timer_o, 1'b0);
      rdr(8'h20);
      chk(rsp, 2'h2);
      // unmapped write is refused but still answered
      wr(8'h20, 32'h0000_0001);
      chk(wsp, 2'h2);
      rdr(cft_pkg::CFT_OFF_CTRL);
      chk(rd, cft_pkg::CFT_CTRL_RST);
   endtask

   // both trigger polarities; the run pulse ends long before the output does
   task automatic t_pulse();
      for (int l = 0; l < 2; l++) begin
         // polarity first, so parking the pin at its inactive level is no trigger
         wr(cft_pkg::CFT_OFF_CTRL, 32'h41 | (l << 4));
         pin(l == 0, 1'b0, 6);
         wr(cft_pkg::CFT_OFF_TIME, 32'h5);
         pin(l == 1, 1'b0, 1);
         pin(l == 0, 1'b0, 12);
         chk(timer_o, 1'b1);
         rdr(cft_pkg::CFT_OFF_ELAP);
         chk(rd > 32'h0 && rd < 32'h5, 1'b1);
         repeat (30) @(posedge clk_i);
         chk(timer_o, 1'b0);
         rdr(cft_pkg::CFT_OFF_ELAP);
         chk(rd, 32'h0);
      end
   endtask

   task automatic t_delay();
      pin(1'b0, 1'b0, 2);
      wr(cft_pkg::CFT_OFF_CTRL, 32'h12);
      chk(wsp, 2'h0);
      wr(cft_pkg::CFT_OFF_TIME, 32'h5);
      pin(1'b1, 1'b0, 10);
      chk(timer_o, 1'b1);
      pin(1'b0, 1'b0, 8);
      chk(timer_o, 1'b1);
      pin(1'b1, 1'b0, 40);
      chk(timer_o, 1'b0);
      rdr(cft_pkg::CFT_OFF_ELAP);
      chk(rd, 32'h5);
      pin(1'b0, 1'b0, 6);
      chk(timer_o, 1'b1);
      rdr(cft_pkg::CFT_OFF_ELAP);
      chk(rd, 32'h0);
   endtask

   task automatic t_oneshot();
      pin(1'b0, 1'b0, 2);
      wr(cft_pkg::CFT_OFF_CTRL, 32'h53);
      wr(cft_pkg::CFT_OFF_TIME, 32'h3);
      repeat (30) @(posedge clk_i);
      chk(timer_o, 1'b1);
      rdr(cft_pkg::CFT_OFF_TIME);
      chk(rd, 32'h3);
      rdr(cft_pkg::CFT_OFF_ELAP);
      chk(rd, 32'h0);
      pin(1'b1, 1'b0, 40);
      chk(timer_o, 1'b0);
      rdr(cft_pkg::CFT_OFF_TIME);
      chk(rd, 32'h0);
      rdr(cft_pkg::CFT_OFF_ELAP);
      chk(rd, 32'h0);
   endtask

   task automatic t_retent();
      pin(1'b0, 1'b0, 2);
      // pass through off so no active state is carried over from one-shot
      wr(cft_pkg::CFT_OFF_CTRL, 32'h70);
      wr(cft_pkg::CFT_OFF_TIME, 32'h2);
      wr(cft_pkg::CFT_OFF_CTRL, 32'h74);
      chk(timer_o, 1'b0);
      pin(1'b1, 1'b0, 20);
      pin(1'b0, 1'b0, 6);
      chk(timer_o, 1'b1);
      rdr(cft_pkg::CFT_OFF_ELAP);
      e1 = rd;
      chk(e1 > 32'h2, 1'b1);
      repeat (20) @(posedge clk_i);
      rdr(cft_pkg::CFT_OFF_ELAP);
      chk(rd, e1);
      chk(timer_o, 1'b1);
      pin(1'b0, 1'b1, 8);
      chk(timer_o, 1'b0);
      rdr(cft_pkg::CFT_OFF_ELAP);
      chk(rd, 32'h0);
      pin(1'b0, 1'b0, 2);
   endtask

   task automatic end_sim();
      if (n_errors == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial begin
      repeat (4) @(posedge clk_i);
      rst_n_i <= 1'b1;
      t_reset();
      t_pulse();
      t_delay();
      t_oneshot();
      t_retent();
      end_sim();
   end

   // whole run is a few hundred cycles
   initial begin
      #100000;
      n_errors++;
      end_sim();
   end
endmodule
